// ### rtl/mode_word_pkg.sv
package mode_word_pkg;

	// Bus widths
	localparam int ADDR_W  = 8'h12;
	localparam int SEL_W   = 8'h03;
	localparam int WORDS_N = 8'h06;
	localparam int REC_W   = 8'h05;
	localparam int RL_W    = 8'h06;
	localparam int WL_W    = 8'h05;

	// Register selector codes
	localparam logic [2:0] SEL_FIRST        = 3'h0;
	localparam logic [2:0] SEL_SECOND       = 3'h1;
	localparam logic [2:0] SEL_THIRD        = 3'h2;
	localparam logic [2:0] SEL_CONTROL_WORD = 3'h7;

	// First word field positions
	localparam int WR_HI_POS  = 8'h0D;
	localparam int WR_LO_LSB  = 8'h09;
	localparam int RL_HI_POS  = 8'h0C;
	localparam int RL_MID_LSB = 8'h04;
	localparam int RL_LO_POS  = 8'h02;

	// Second word field positions
	localparam int OUT_DISABLE_POS = 8'h0C;
	localparam int STROBE_POS      = 8'h0B;
	localparam int NOM_LSB         = 8'h08;
	localparam int LEVEL_POS       = 8'h07;
	localparam int AL_LSB          = 8'h03;
	localparam int DRV_LSB         = 8'h01;
	localparam int DLL_POS         = 8'h00;

	// Third word field positions
	localparam int CRC_POS = 8'h0C;
	localparam int WRT_LSB = 8'h09;
	localparam int SRR_LSB = 8'h06;
	localparam int WL_LSB  = 8'h03;

	// Bits that must be written as zero, per word
	localparam logic [ADDR_W-1:0] FIRST_RSV_MASK  = 18'h20000;
	localparam logic [ADDR_W-1:0] SECOND_RSV_MASK = 18'h22060;
	localparam logic [ADDR_W-1:0] THIRD_RSV_MASK  = 18'h22107;

	// Decode tables, entry 0 on the right
	localparam logic [4:0] REC_CODES = 5'h09;
	localparam logic [8:0][REC_W-1:0] RECOVERY_TBL = {5'h1A, 5'h16, 5'h18, 5'h14, 5'h12,
		5'h10, 5'h0E, 5'h0C, 5'h0A};
	localparam logic [5:0] RL_CODES = 6'h18;
	localparam logic [4:0] RL_STACK_A = 5'h10;
	localparam logic [4:0] RL_STACK_B = 5'h12;
	localparam logic [4:0] RL_RSV_A   = 5'h14;
	localparam logic [4:0] RL_RSV_B   = 5'h16;
	localparam logic [23:0][RL_W-1:0] READ_LAT_TBL = {6'h20, 6'h1F, 6'h1E, 6'h1D, 6'h1C,
		6'h1B, 6'h1A, 6'h19, 6'h15, 6'h13, 6'h11, 6'h17, 6'h18, 6'h16, 6'h14, 6'h12,
		6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h09};
	localparam logic [7:0][WL_W-1:0] WRITE_LAT_TBL = {5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C,
		5'h0B, 5'h0A, 5'h09};
	localparam logic [RL_W-1:0] AL_STEP_ONE = 6'h01;
	localparam logic [RL_W-1:0] AL_STEP_TWO = 6'h02;

	// Field encodings, listed in code order
	typedef enum logic [2:0] {NOM_OFF, NOM_REF_DIV4, NOM_REF_DIV2, NOM_REF_DIV6,
		NOM_REF_DIV1, NOM_REF_DIV5, NOM_REF_DIV3, NOM_REF_DIV7} nominal_termination_t;
	typedef enum logic [2:0] {WRT_OFF, WRT_REF_DIV2, WRT_REF_DIV1, WRT_HIZ, WRT_REF_DIV3,
		WRT_RSV5, WRT_RSV6, WRT_RSV7} write_termination_t;
	typedef enum logic [1:0] {DRV_REF_DIV7, DRV_REF_DIV5, DRV_RSV2, DRV_RSV3} driver_strength_t;
	typedef enum logic [1:0] {AL_ZERO, AL_MINUS_ONE, AL_MINUS_TWO, AL_UNDEF} added_latency_t;
	typedef enum logic [1:0] {SRR_NORMAL, SRR_REDUCED, SRR_EXTENDED,
		SRR_AUTO} self_refresh_range_t;

	// Mode-register-set command as seen on the pins
	typedef struct packed {
		logic              valid;
		logic [1:0]        bank_group;
		logic [1:0]        bank;
		logic [ADDR_W-1:0] addr;
	} mode_cmd_t;

	typedef struct packed {
		logic [3:0]       recovery_code;
		logic [REC_W-1:0] write_recovery;
		logic [REC_W-1:0] read_to_precharge_cycles;
		logic             recovery_reserved;
		logic [4:0]       latency_code;
		logic [RL_W-1:0]  read_latency;
		logic             latency_reserved;
	} first_mode_word_t;

	typedef struct packed {
		logic                 output_disable;
		logic                 termination_strobe;
		nominal_termination_t nominal_termination;
		logic                 write_leveling;
		added_latency_t       added_latency;
		driver_strength_t     driver_strength;
		logic                 dll_enable;
	} second_mode_word_t;

	typedef struct packed {
		logic                write_crc;
		write_termination_t  write_termination;
		self_refresh_range_t self_refresh_range;
		logic [2:0]          write_latency_code;
		logic [WL_W-1:0]     write_latency;
	} third_mode_word_t;

	localparam first_mode_word_t  FIRST_RESET  = '0;
	localparam second_mode_word_t SECOND_RESET = '0;
	localparam third_mode_word_t  THIRD_RESET  = '0;

endpackage

// ### rtl/recovery_decode.sv
`timescale 1ns/1ps
module recovery_decode (
	input  wire logic [3:0]                   code,
	output logic [mode_word_pkg::REC_W-1:0]   write_recovery,
	output logic [mode_word_pkg::REC_W-1:0]   read_to_precharge_cycles,
	output logic                              reserved
);
	import mode_word_pkg::*;

	// Table lookup; codes past the table are reserved and read zero
	always_comb begin
		reserved = ({1'b0, code} >= REC_CODES);
		write_recovery = '0;
		if (!reserved) begin
			write_recovery = RECOVERY_TBL[code];
		end
		// Precharge delay is half the recovery for every defined code
		read_to_precharge_cycles = write_recovery >> 1;
	end

endmodule

// ### rtl/read_latency_decode.sv
`timescale 1ns/1ps
module read_latency_decode (
	input  wire logic [4:0]                  code,
	input  wire logic                        stacked_die,
	output logic [mode_word_pkg::RL_W-1:0]   read_latency,
	output logic                             reserved
);
	import mode_word_pkg::*;

	// Reserved codes: beyond table, held slots, and stacked-only values on plain parts
	always_comb begin
		reserved = ({1'b0, code} >= RL_CODES) || (code == RL_RSV_A) || (code == RL_RSV_B)
			|| (!stacked_die && ((code == RL_STACK_A) || (code == RL_STACK_B)));
		read_latency = '0;
		if (!reserved) begin
			read_latency = READ_LAT_TBL[code];
		end
	end

endmodule

// ### rtl/sdram_mode_register_decode.sv
`timescale 1ns/1ps
module sdram_mode_register_decode (
	input  wire logic                                core_clk,
	input  wire logic                                reset,
	input  wire mode_word_pkg::mode_cmd_t            mode_cmd,
	input  wire logic                                stacked_die,
	output mode_word_pkg::first_mode_word_t          first_mode_word,
	output mode_word_pkg::second_mode_word_t         output_termination_mode_word,
	output mode_word_pkg::third_mode_word_t          write_latency_mode_word,
	output logic [mode_word_pkg::RL_W-1:0]           added_latency_cycles,
	output logic                                     added_latency_undefined,
	output logic                                     data_buffers_enabled,
	output logic                                     strobe_buffers_enabled,
	output logic [mode_word_pkg::WORDS_N-1:0]        register_written,
	output logic                                     reserved_bits_seen
);
	import mode_word_pkg::*;

	// Selector to one-hot; the control word code gives no bit at all
	function automatic logic [WORDS_N-1:0] select_onehot(input logic [SEL_W-1:0] sel);
		logic [WORDS_N-1:0] hot;
		hot = '0;
		if (sel < SEL_W'(WORDS_N)) begin
			hot[sel] = 1'b1;
		end
		return hot;
	endfunction

	// Write latency lookup, used by the store path
	function automatic logic [WL_W-1:0] write_latency_of(input logic [2:0] code);
		return WRITE_LAT_TBL[code];
	endfunction

	logic [SEL_W-1:0]   sel;
	logic [ADDR_W-1:0]  a;
	logic               accept;
	logic [3:0]         rec_code;
	logic [4:0]         rl_code;
	logic [REC_W-1:0]   rec_cycles;
	logic [REC_W-1:0]   rtp_cycles;
	logic               rec_reserved;
	logic [RL_W-1:0]    rl_cycles;
	logic               rl_reserved;

	first_mode_word_t   first_r;
	first_mode_word_t   first_nxt;
	second_mode_word_t  second_r;
	second_mode_word_t  second_nxt;
	third_mode_word_t   third_r;
	third_mode_word_t   third_nxt;
	logic [WORDS_N-1:0] written_r;
	logic [WORDS_N-1:0] written_nxt;
	logic               rsv_seen_r;
	logic               rsv_seen_nxt;
	logic [RL_W-1:0]    added_r;
	logic [RL_W-1:0]    added_nxt;
	logic               added_undef_r;
	logic               added_undef_nxt;

	// Selector rides on bank group bit 0 and the bank bits
	assign sel = {mode_cmd.bank_group[0], mode_cmd.bank};
	assign a   = mode_cmd.addr;
	assign accept = mode_cmd.valid && (sel != SEL_CONTROL_WORD);

	assign rec_code = {a[WR_HI_POS], a[WR_LO_LSB +: 3]};
	assign rl_code  = {a[RL_HI_POS], a[RL_MID_LSB +: 3], a[RL_LO_POS]};

	recovery_decode u_recovery (
		.code                     (rec_code),
		.write_recovery           (rec_cycles),
		.read_to_precharge_cycles (rtp_cycles),
		.reserved                 (rec_reserved)
	);

	read_latency_decode u_read_latency (
		.code         (rl_code),
		.stacked_die  (stacked_die),
		.read_latency (rl_cycles),
		.reserved     (rl_reserved)
	);

	// Next values; a write replaces every field of the addressed word at once
	always_comb begin
		first_nxt    = first_r;
		second_nxt   = second_r;
		third_nxt    = third_r;
		rsv_seen_nxt = rsv_seen_r;
		written_nxt  = accept ? select_onehot(sel) : '0;
		if (accept) begin
			// Reserved bits are only reported; the controller owns them
			rsv_seen_nxt = mode_cmd.bank_group[1];
			unique case (sel)
				SEL_FIRST: begin
					first_nxt.recovery_code            = rec_code;
					first_nxt.write_recovery           = rec_cycles;
					first_nxt.read_to_precharge_cycles = rtp_cycles;
					first_nxt.recovery_reserved        = rec_reserved;
					first_nxt.latency_code             = rl_code;
					first_nxt.read_latency             = rl_cycles;
					first_nxt.latency_reserved         = rl_reserved;
					rsv_seen_nxt = mode_cmd.bank_group[1] || |(a & FIRST_RSV_MASK);
				end
				SEL_SECOND: begin
					second_nxt.output_disable      = a[OUT_DISABLE_POS];
					second_nxt.termination_strobe  = a[STROBE_POS];
					second_nxt.nominal_termination = nominal_termination_t'(a[NOM_LSB +: 3]);
					second_nxt.write_leveling      = a[LEVEL_POS];
					second_nxt.added_latency       = added_latency_t'(a[AL_LSB +: 2]);
					second_nxt.driver_strength     = driver_strength_t'(a[DRV_LSB +: 2]);
					second_nxt.dll_enable          = a[DLL_POS];
					rsv_seen_nxt = mode_cmd.bank_group[1] || |(a & SECOND_RSV_MASK);
				end
				SEL_THIRD: begin
					third_nxt.write_crc          = a[CRC_POS];
					third_nxt.write_termination  = write_termination_t'(a[WRT_LSB +: 3]);
					third_nxt.self_refresh_range = self_refresh_range_t'(a[SRR_LSB +: 2]);
					third_nxt.write_latency_code = a[WL_LSB +: 3];
					third_nxt.write_latency      = write_latency_of(a[WL_LSB +: 3]);
					rsv_seen_nxt = mode_cmd.bank_group[1] || |(a & THIRD_RSV_MASK);
				end
				default: begin
					// Fourth to sixth words belong to other blocks; only the strobe and the bank group bit 1 reserved flag show
				end
			endcase
		end
	end

	// Added latency tracks read latency one cycle late, so a later first-word
	// write is picked up without rewriting the second word
	always_comb begin
		added_nxt       = '0;
		added_undef_nxt = 1'b0;
		unique case (second_r.added_latency)
			AL_ZERO: begin
				added_nxt = '0;
			end
			AL_MINUS_ONE: begin
				if (first_r.read_latency >= AL_STEP_ONE) begin
					added_nxt = first_r.read_latency - AL_STEP_ONE;
				end
			end
			AL_MINUS_TWO: begin
				if (first_r.read_latency >= AL_STEP_TWO) begin
					added_nxt = first_r.read_latency - AL_STEP_TWO;
				end
			end
			AL_UNDEF: begin
				added_undef_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			first_r       <= FIRST_RESET;
			second_r      <= SECOND_RESET;
			third_r       <= THIRD_RESET;
			written_r     <= '0;
			rsv_seen_r    <= 1'b0;
			added_r       <= '0;
			added_undef_r <= 1'b0;
		end else begin
			first_r       <= first_nxt;
			second_r      <= second_nxt;
			third_r       <= third_nxt;
			written_r     <= written_nxt;
			rsv_seen_r    <= rsv_seen_nxt;
			added_r       <= added_nxt;
			added_undef_r <= added_undef_nxt;
		end
	end

	// Outputs straight from the stored words
	assign first_mode_word              = first_r;
	assign output_termination_mode_word = second_r;
	assign write_latency_mode_word      = third_r;
	assign added_latency_cycles         = added_r;
	assign added_latency_undefined      = added_undef_r;
	assign register_written             = written_r;
	assign reserved_bits_seen           = rsv_seen_r;
	assign data_buffers_enabled   = !second_r.output_disable;
	assign strobe_buffers_enabled = !second_r.output_disable;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// Command shapes reused by the checks
	sequence s_write(logic [SEL_W-1:0] s);
		mode_cmd.valid && (sel == s);
	endsequence

	sequence s_idle;
		!mode_cmd.valid;
	endsequence

	property p_control_ignored;
		s_write(SEL_CONTROL_WORD) |=> (register_written == '0) && $stable(first_r)
			&& $stable(second_r) && $stable(third_r);
	endproperty
	a_control_ignored: assert property (p_control_ignored)
		else $error("control word write changed state");

	property p_recovery_half;
		s_write(SEL_FIRST) ##1 !first_r.recovery_reserved |->
			(first_r.read_to_precharge_cycles << 1) == first_r.write_recovery;
	endproperty
	a_recovery_half: assert property (p_recovery_half)
		else $error("precharge delay is not half of recovery");

	property p_recovery_top;
		s_write(SEL_FIRST) and (rec_code == 4'h8) |=> first_r.write_recovery == 5'h1A
			&& first_r.read_to_precharge_cycles == 5'h0D;
	endproperty
	a_recovery_top: assert property (p_recovery_top)
		else $error("recovery code 8 not decoded to 26");

	property p_latency_23;
		s_write(SEL_FIRST) and (rl_code == 5'h0C) |=> first_r.read_latency == 6'h17
			&& !first_r.latency_reserved;
	endproperty
	a_latency_23: assert property (p_latency_23)
		else $error("latency code 0C not decoded to 23");

	property p_stacked_only;
		s_write(SEL_FIRST) and (rl_code == RL_STACK_A) |=>
			first_r.latency_reserved == !$past(stacked_die);
	endproperty
	a_stacked_only: assert property (p_stacked_only)
		else $error("stacked-only latency not flagged correctly");

	property p_out_disable;
		s_write(SEL_SECOND) |=> (data_buffers_enabled == !$past(a[OUT_DISABLE_POS]))
			&& (strobe_buffers_enabled == data_buffers_enabled);
	endproperty
	a_out_disable: assert property (p_out_disable)
		else $error("output buffers not following disable bit");

	property p_strobe_term;
		s_write(SEL_SECOND) |=> second_r.termination_strobe == $past(a[STROBE_POS])
			&& second_r.dll_enable == $past(a[DLL_POS]);
	endproperty
	a_strobe_term: assert property (p_strobe_term)
		else $error("strobe or loop bit not stored");

	property p_added_minus_one;
		(second_r.added_latency == AL_MINUS_ONE) && (first_r.read_latency != '0) |=>
			added_latency_cycles == $past(first_r.read_latency) - AL_STEP_ONE;
	endproperty
	a_added_minus_one: assert property (p_added_minus_one)
		else $error("added latency not read latency minus one");

	property p_write_latency_top;
		s_write(SEL_THIRD) and (a[WL_LSB +: 3] == 3'h7) |=>
			third_r.write_latency == 5'h14 ##1 ($stable(third_r) || $past(mode_cmd.valid));
	endproperty
	a_write_latency_top: assert property (p_write_latency_top)
		else $error("write latency code 7 not decoded to 20");

	property p_hold;
		s_idle |=> $stable(first_r) && $stable(second_r) && $stable(third_r)
			&& register_written == '0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("settings changed without a write");

	property p_select_pulse;
		s_write(3'h5) ##1 s_idle |-> register_written == 6'h20 ##1 register_written == '0;
	endproperty
	a_select_pulse: assert property (p_select_pulse)
		else $error("sixth word write strobe wrong");

	property p_third_only;
		s_write(SEL_THIRD) |=> $stable(first_r) && $stable(second_r);
	endproperty
	a_third_only: assert property (p_third_only)
		else $error("third word write disturbed another word");

	// Field checks read the raw address, so a wrong bit position shows up here
	property p_nominal_term;
		s_write(SEL_SECOND) |=> second_r.nominal_termination == $past(a[NOM_LSB +: 3])
			&& second_r.driver_strength == $past(a[DRV_LSB +: 2])
			&& second_r.write_leveling == $past(a[LEVEL_POS]);
	endproperty
	a_nominal_term: assert property (p_nominal_term)
		else $error("second word termination or driver field not stored");

	property p_write_term;
		s_write(SEL_THIRD) |=> third_r.write_termination == $past(a[WRT_LSB +: 3])
			&& third_r.self_refresh_range == $past(a[SRR_LSB +: 2])
			&& third_r.write_crc == $past(a[CRC_POS]);
	endproperty
	a_write_term: assert property (p_write_term)
		else $error("third word termination, refresh or check field not stored");

	property p_write_latency_code;
		s_write(SEL_THIRD) |=> third_r.write_latency_code == $past(a[WL_LSB +: 3]);
	endproperty
	a_write_latency_code: assert property (p_write_latency_code)
		else $error("write latency code not stored");

	property p_first_codes;
		s_write(SEL_FIRST) |=> first_r.latency_code == {$past(a[RL_HI_POS]),
			$past(a[RL_MID_LSB +: 3]), $past(a[RL_LO_POS])}
			&& first_r.recovery_code[3] == $past(a[WR_HI_POS]);
	endproperty
	a_first_codes: assert property (p_first_codes)
		else $error("first word codes gathered from wrong bits");

endmodule

// ### dv/mrs_controller_model.sv
`timescale 1ns/1ps
// Controller side of the mode-register-set path, one command at a time
module mrs_controller_model #(
	parameter int MRD_CYCLES = 4
) (
	input  wire logic             core_clk,
	output mode_word_pkg::mode_cmd_t mode_cmd
);
	import mode_word_pkg::*;

	initial begin
		mode_cmd = '0;
	end

	// Send one command; break_rsv drives must-be-zero bits as given
	task automatic issue(input logic bg1, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic break_rsv);
		logic [ADDR_W-1:0] mask;
		mask = (sel == SEL_FIRST) ? FIRST_RSV_MASK :
			(sel == SEL_SECOND) ? SECOND_RSV_MASK :
			(sel == SEL_THIRD) ? THIRD_RSV_MASK : '0;
		repeat (MRD_CYCLES) @(negedge core_clk);
		mode_cmd.valid      = 1'b1;
		mode_cmd.bank_group = {bg1 & break_rsv, sel[2]};
		mode_cmd.bank       = sel[1:0];
		mode_cmd.addr       = break_rsv ? a : (a & ~mask);
		@(negedge core_clk);
		// Released lines flip so a stale word never looks like a command
		mode_cmd.valid      = 1'b0;
		mode_cmd.bank_group = ~mode_cmd.bank_group;
		mode_cmd.bank       = ~mode_cmd.bank;
		mode_cmd.addr       = ~mode_cmd.addr;
	endtask
endmodule

// ### dv/test_sdram_mode_register_decode.sv
`timescale 1ns/1ps
module test_sdram_mode_register_decode;
	import mode_word_pkg::*;

	typedef struct packed {
		logic [2:0]  sel;
		logic [17:0] addr;
		logic [13:0] exp;
	} row_t;

	logic                core_clk;
	logic                reset;
	logic                stacked_die;
	mode_cmd_t           mode_cmd;
	first_mode_word_t    fw;
	second_mode_word_t   sw;
	third_mode_word_t    tw;
	logic [RL_W-1:0]     al_cycles;
	logic                al_undef;
	logic                data_en;
	logic                strobe_en;
	logic [WORDS_N-1:0]  written;
	logic                rsv_seen;
	int                  failures;
	int                  num_checks;
	int                  e;
	int rec_tbl[9] = '{10, 12, 14, 16, 18, 20, 24, 22, 26};
	int rl_tbl[32] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21,
		25, 26, 27, 28, 0, 30, 0, 32, 0, 0, 0, 0, 0, 0, 0, 0};
	int wl_tbl[8] = '{9, 10, 11, 12, 14, 16, 18, 20};
	// Ordinary cases: selector, address, packed word expected
	row_t rows[9] = '{'{SEL_SECOND, 18'h01001, 14'h0401}, '{SEL_SECOND, 18'h00800, 14'h0200},
		'{SEL_SECOND, 18'h00080, 14'h0020}, '{SEL_SECOND, 18'h0001A, 14'h001A},
		'{SEL_THIRD, 18'h01000, 14'h2009}, '{SEL_THIRD, 18'h00E00, 14'h1C09},
		'{SEL_THIRD, 18'h000C0, 14'h0309}, '{SEL_THIRD, 18'h00038, 14'h00F4},
		'{SEL_THIRD, 18'h00000, 14'h0009}};

	sdram_mode_register_decode dut_u (
		.core_clk                     (core_clk),
		.reset                        (reset),
		.mode_cmd                     (mode_cmd),
		.stacked_die                  (stacked_die),
		.first_mode_word              (fw),
		.output_termination_mode_word (sw),
		.write_latency_mode_word      (tw),
		.added_latency_cycles         (al_cycles),
		.added_latency_undefined      (al_undef),
		.data_buffers_enabled         (data_en),
		.strobe_buffers_enabled       (strobe_en),
		.register_written             (written),
		.reserved_bits_seen           (rsv_seen)
	);

	mrs_controller_model ctrl_u (
		.core_clk (core_clk),
		.mode_cmd (mode_cmd)
	);

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
	end
	always #5 core_clk = ~core_clk;

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic write(input logic [2:0] sel, input logic [17:0] a);
		ctrl_u.issue(1'b0, sel, a, 1'b0);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// About 600 cycles of traffic; over thirty times that means a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		stacked_die = 1'b0;
		failures = 0;
		num_checks = 0;
		repeat (3) @(negedge core_clk);
		check("reset words", 32'h0, 32'({sw, tw}));
		check("reset buffers", 32'hC0, 32'({data_en, strobe_en, written}));
		check("reset first word", 32'h0, 32'({fw, rsv_seen}));
		check("reset added latency", 32'h0, 32'({al_undef, al_cycles}));
		reset = 1'b0;
		$display("test reset done");
		foreach (rows[i]) begin
			write(rows[i].sel, rows[i].addr);
			check("register_written", 32'(6'h01 << rows[i].sel), 32'(written));
			if (rows[i].sel == SEL_SECOND) begin
				check("second word", 32'(rows[i].exp[10:0]), 32'(sw));
				check("buffers", 32'({2{~rows[i].exp[10]}}), 32'({data_en, strobe_en}));
			end else begin
				check("third word", 32'(rows[i].exp), 32'(tw));
			end
		end
		$display("test rows done");
		// Every code of the multi-bit fields, but only driver strength codes 0 and 1
		for (int i = 0; i < 8; i++) begin
			write(SEL_SECOND, 18'((i << 8) | ((i % 4) << 3) | ((i % 2) << 1)));
			check("second word", 32'((i << 6) | ((i % 4) << 3) | ((i % 2) << 1)), 32'(sw));
			write(SEL_THIRD, 18'((i << 9) | ((i % 4) << 6) | (i << 3)));
			check("third word", 32'((i << 10) | ((i % 4) << 8) | (i << 5) | wl_tbl[i]),
				32'(tw));
		end
		$display("test field codes done");
		for (int i = 0; i < 16; i++) begin
			write(SEL_FIRST, 18'(((i / 8) << 13) | ((i % 8) << 9)));
			e = (i < 9) ? rec_tbl[i] : 0;
			check("recovery", 32'({4'(i), i >= 9, 5'(e), 5'(e / 2)}), 32'({fw.recovery_code,
				fw.recovery_reserved, fw.write_recovery, fw.read_to_precharge_cycles}));
		end
		$display("test recovery done");
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 32; c++) begin
				// stacked-only codes tried on both part kinds
				stacked_die = s[0];
				write(SEL_FIRST, 18'(((c / 16) << 12) | (((c / 2) % 8) << 4) | ((c % 2) << 2)));
				e = (s == 0 && (c == 16 || c == 18)) ? 0 : rl_tbl[c];
				check("read latency", 32'({5'(c), e == 0, 6'(e)}),
					32'({fw.latency_code, fw.latency_reserved, fw.read_latency}));
			end
		end
		$display("test read latency done");
		// Read latency 10, then each added-latency code
		write(SEL_FIRST, 18'h00004);
		for (int a = 0; a < 4; a++) begin
			write(SEL_SECOND, 18'(a << 3));
			@(negedge core_clk);
			e = (a == 1) ? 9 : (a == 2) ? 8 : 0;
			check("added latency", 32'({a == 3, 6'(e)}), 32'({al_undef, al_cycles}));
		end
		$display("test added latency done");
		// Control-word and unstored selectors leave every word alone
		write(SEL_SECOND, 18'h01001);
		for (int s = 3; s < 8; s++) begin
			write(3'(s), 18'h3FFFF);
			check("register_written", 32'((s < 6) ? (1 << s) : 0), 32'(written));
			check("second word", 32'h401, 32'(sw));
		end
		check("third word", 32'((7 << 10) | (3 << 8) | (7 << 5) | 20), 32'(tw));
		$display("test selectors done");
		ctrl_u.issue(1'b1, SEL_SECOND, 18'h00060, 1'b1);
		check("reserved seen", 32'h1, 32'(rsv_seen));
		write(SEL_SECOND, 18'h00060);
		check("reserved seen", 32'h0, 32'(rsv_seen));
		$display("test reserved bits done");
		// Second reset in mid-run clears the stored words
		write(SEL_SECOND, 18'h01001);
		reset = 1'b1;
		@(negedge core_clk);
		check("reset words", 32'h1, 32'({sw, data_en}));
		reset = 1'b0;
		// The block must take commands again after a mid-run reset
		write(SEL_SECOND, 18'h00800);
		check("second word", 32'h200, 32'(sw));
		$display("test mid reset done");
		print_verdict();
	end
endmodule
